// File: dv/itc_counter_properties.sv
`timescale 1ns/10ps
module itc_counter_properties
	import itc_pkg::*;
#(parameter logic [3:0][31:0] WIN_CYC = ITC_WIN_CYC)
(
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// Panel and display
	input wire itc_panel_s panel,
	input wire itc_disp_s  disp
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_rst_zero: assert property (
		$fell(rst) |-> disp.value == ITC_ZERO27) else $error("reset value");
	a_acc_no_lamp: assert property (
		(panel.measurement_function_select == ITC_F_TOTAL)[*4] |-> !disp.lit_ms_mhz && !disp.lit_us_khz)
		else $error("unit lamp in accumulate");
	a_ms_lamp: assert property (
		(panel.measurement_function_select == ITC_F_TIME && panel.unit_ms)[*4]
		|-> disp.lit_ms_mhz && !disp.lit_us_khz) else $error("ms lamp");
	a_ms_skip: assert property (
		disp.lit_ms_mhz && panel.measurement_function_select == ITC_F_TIME && $past(disp.win_sel) == 2'h2
		&& disp.win_sel != 2'h2 |-> disp.win_sel == 2'h0) else $error("10 s");
	a_clear_zero: assert property (
		panel.clear[*4] |-> disp.value == ITC_ZERO27 && !disp.window_active)
		else $error("clear not zero");
	a_hold_frozen: assert property (
		(panel.hold && !panel.clear)[*5] |-> $stable(disp.value))
		else $error("held value moved");
	a_gate_blocks: assert property (
		(panel.measurement_function_select == ITC_F_TOTAL && panel.gate_present && !panel.gate
		&& !panel.clear)[*5] |-> $stable(disp.value)) else $error("gate");
	a_shot_wait: assert property (
		$fell(disp.window_active) && $changed(disp.value)
		&& panel.measurement_function_select == ITC_F_TIME && disp.win_sel == 2'h0
		&& disp.value != 27'h0 |=> (!disp.window_active)[*6])
		else $error("single shot rearmed");

	c_shot: cover property ($fell(disp.window_active));
	c_count: cover property ($changed(disp.value));
	c_fold: cover property ($rose(disp.win_sel == 2'h0));
endmodule

bind itc_counter itc_counter_properties #(.WIN_CYC(WIN_CYC)) u_props (
	.core_clk(core_clk), .rst(rst), .panel(panel), .disp(disp));

// File: dv/itc_far_end.sv
`timescale 1ns/10ps
module itc_far_end
#(parameter int GAP = 20)
(
	// Clock and request
	input  wire logic core_clk,
	input  wire logic go,
	// Conditioned channels
	output logic      chan_a = 1'h0,
	output logic      chan_b = 1'h0
);
	// A high 2 cycles; B rises GAP after A, high 5
	always @(posedge go)
	begin
		@(negedge core_clk);
		chan_a = 1'h1;
		repeat (2) @(negedge core_clk);
		chan_a = 1'h0;
		repeat (GAP - 2) @(negedge core_clk);
		chan_b = 1'h1;
		repeat (5) @(negedge core_clk);
		chan_b = 1'h0;
	end
endmodule

// File: dv/test_interval_totalize_check_counter.sv
`timescale 1ns/10ps
module test_interval_totalize_check_counter
	import itc_pkg::*;
();
	localparam logic [4:0][2:0] ACC_IN = {3'h6, 3'h7, 3'h6, 3'h4, 3'h0};
	localparam logic [4:0][2:0] ACC_EXP = {3'h3, 3'h2, 3'h2, 3'h1, 3'h1};
	logic       core_clk;
	logic       rst;
	itc_panel_s panel;
	logic       go = 1'h0;
	logic       chan_a;
	logic       chan_b;
	logic       slope_a_neg;
	logic       slope_b_neg;
	itc_disp_s  disp;
	int         n_errors = 0;
	int         n_tests = 0;
	itc_counter #(.WIN_CYC({32'hFA0, 32'h190, 32'h64, 32'h32})) u_dut (
		.core_clk(core_clk), .rst(rst), .panel(panel), .chan_a(chan_a),
		.chan_b(chan_b), .slope_a_neg(slope_a_neg),
		.slope_b_neg(slope_b_neg), .disp(disp));
	itc_far_end u_far (.core_clk(core_clk), .go(go), .chan_a(chan_a),
		.chan_b(chan_b));
	initial
	begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk(input logic [26:0] s, input logic [26:0] e);
		n_tests++;
		if (s !== e)
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		n_errors += int'(s !== e);
	endtask
	task automatic conclude;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Bounded wait for the shown value, then compare
	task automatic see_val(input logic [26:0] e);
		int i;
		for (i = 0; i < 900 && disp.value !== e; i++)
			cyc(1);
		chk(disp.value, e);
		if (disp.value !== e)
			conclude();
	endtask
	task automatic fire;
		go = 1'h1;
		cyc(1);
		go = 1'h0;
		cyc(30);
	endtask
	task automatic step;
		panel.win_step = 1'h1;
		cyc(3);
		panel.win_step = 1'h0;
		cyc(3);
	endtask
	task automatic press;
		panel.clear = 1'h1;
		cyc(5);
		chk(27'(disp.window_active), 27'h0);
		see_val(27'h0);
		panel.clear = 1'h0;
		cyc(4);
	endtask
	initial
	begin
		rst = 1'h1;
		panel = '0;
		slope_a_neg = 1'h0;
		slope_b_neg = 1'h0;
		cyc(12);
		rst = 1'h0;
		panel.unit_ms = 1'h1;
		cyc(4);
		chk(27'(disp.lit_ms_mhz), 27'h1);
		chk(27'(disp.lit_us_khz), 27'h0);
		repeat (3) step();
		chk(27'(disp.win_sel), 27'h0);
		fire();
		see_val(27'h14);
		chk(27'(disp.display_limit_exceeded), 27'h0);
		cyc(20);
		chk(27'(disp.window_active), 27'h0);
		slope_a_neg = 1'h1;
		slope_b_neg = 1'h1;
		press();
		fire();
		see_val(27'h17);
		panel.measurement_function_select = ITC_F_TOTAL;
		press();
		step();
		chk(27'(disp.win_sel), 27'h0);
		chk(27'(disp.lit_ms_mhz), 27'h0);
		chk(27'(disp.lit_us_khz), 27'h0);
		// Gate absent, gate low, gate high, hold, release
		for (int k = 0; k < 5; k++)
		begin
			{panel.gate_present, panel.gate, panel.hold} = ACC_IN[k];
			cyc(4);
			fire();
			see_val(27'(ACC_EXP[k]));
		end
		panel.measurement_function_select = ITC_F_CHECK;
		press();
		chk(27'(disp.blank_int_digits), 27'h1);
		see_val(27'h2);
		chk(27'(disp.blank_int_digits), 27'h0);
		step();
		see_val(27'h4);
		panel.hold = 1'h1;
		cyc(5);
		chk(27'(disp.window_active), 27'h0);
		conclude();
	end
endmodule

// File: rtl/itc_counter.sv
`timescale 1ns/10ps

// How it works
// - Interval: start on chosen A edge, stop on next chosen B edge, report.
// - Slope select high picks falling edge, low picks rising, per channel.
// - Interval range select high gives ms, low gives us, with unit lamp.
// - Interval in ms range skips 10 s window, 1.0 s steps to 0.01 s.
// - Window lamp on while measuring; display changes only at completion.
// - Limit-exceeded lamp lights when a result overflows the display.
// - Freeze holds display; release restarts, old value until it ends.
// - Reset zeroes display; release restarts, zero until it completes.
// - Single-shot: first window, reset arms, one A then B, then wait.
// - Accumulate mode ignores window selector and unit range select.
// - Gate high counts, low suspends; unconnected gate reads high.
// - After reset release, accumulation starts once gate is high.
// - Total up to 99,999,999; beyond sets limit lamp and wraps to zero.
// - Low gate blocks channel A events in every mode here.
// - Accumulate: freeze stops and holds total, release resumes from it.
// - Accumulate: reset clears count and display whatever gate or freeze.
// - Self-test counts internal 10 MHz reference per window.
// - Self-test freeze holds value, window lamp off while engaged.
// - Self-test reset blanks integer digits, lamp off, refresh after window.
// - New window setting shows only after one full window at it.
// - Window setting selects 1, 10, 100 or 1000 averaged cycles.
module itc_counter
	import itc_pkg::*;
#(
	parameter logic [3:0][31:0] WIN_CYC = ITC_WIN_CYC
)
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Front panel and rear gate
	input  wire itc_panel_s panel,
	// Conditioned channels and slope selects
	input  wire logic       chan_a,
	input  wire logic       chan_b,
	input  wire logic       slope_a_neg,
	input  wire logic       slope_b_neg,
	// Display and lamps
	output itc_disp_s       disp
);

	typedef struct packed {
		itc_panel_s  sy1;
		itc_panel_s  sy2;
		logic        step_q;
		logic        hold_q;
		logic        clear_q;
		logic        a_q;
		logic        b_q;
		logic [1:0]  measurement_function_select_q;
		logic [1:0]  win_q;
		itc_state_e  st;
		logic [31:0] tmr;
		logic [4:0]  ref_cnt;
		logic [26:0] acc;
		logic        acc_ovf;
		logic [9:0]  ncyc;
		itc_disp_s   out;
	} itc_core_s;

	itc_core_s core_reg;
	itc_core_s core_next;

	logic        gate_hi;
	logic        a_edge;
	logic        b_edge;
	logic        a_evt;
	logic        ref_tick;
	logic        restart;
	logic        single;
	logic [32:0] sum;
	logic [26:0] inc;

	always_comb
	begin
		core_next = core_reg;
		core_next.sy1 = panel;
		core_next.sy2 = core_reg.sy1;
		core_next.step_q = core_reg.sy2.win_step;
		core_next.hold_q = core_reg.sy2.hold;
		core_next.clear_q = core_reg.sy2.clear;
		core_next.a_q = chan_a;
		core_next.b_q = chan_b;
		core_next.measurement_function_select_q = core_reg.sy2.measurement_function_select;
		core_next.win_q = core_reg.out.win_sel;

		// Open gate input counts as high
		gate_hi = core_reg.sy2.gate | ~core_reg.sy2.gate_present;
		a_edge = slope_a_neg ? (core_reg.a_q & ~chan_a)
			: (~core_reg.a_q & chan_a);
		b_edge = slope_b_neg ? (core_reg.b_q & ~chan_b)
			: (~core_reg.b_q & chan_b);
		a_evt = a_edge & gate_hi;

		ref_tick = (core_reg.ref_cnt == ITC_REF_DIV - 5'h1);
		core_next.ref_cnt = ref_tick ? ITC_ZERO5
			: core_reg.ref_cnt + 5'h1;

		single = (core_reg.out.win_sel == ITC_WIN_FIRST);
		// Stop edge itself counts as one tick
		sum = {1'b0, core_reg.tmr + 32'h1}
			+ {6'h0, core_reg.acc};
		inc = core_reg.acc + 27'h1;

		// Window selector stepping, not in accumulate
		if (core_reg.sy2.win_step && !core_reg.step_q
			&& core_reg.sy2.measurement_function_select != ITC_F_TOTAL)
		begin
			if (core_reg.out.win_sel == ITC_WIN_LAST
				|| (core_reg.sy2.measurement_function_select == ITC_F_TIME
				&& core_reg.sy2.unit_ms
				&& core_reg.out.win_sel == ITC_WIN_MS_TOP))
				core_next.out.win_sel = ITC_WIN_FIRST;
			else
				core_next.out.win_sel = core_reg.out.win_sel + 2'h1;
		end

		// Unit lamps
		core_next.out.lit_ms_mhz = 1'b0;
		core_next.out.lit_us_khz = 1'b0;
		if (core_reg.sy2.measurement_function_select != ITC_F_TOTAL)
		begin
			core_next.out.lit_ms_mhz = core_reg.sy2.unit_ms;
			core_next.out.lit_us_khz = ~core_reg.sy2.unit_ms;
		end

		// Function or window change restarts, display kept
		restart = (core_reg.measurement_function_select_q != core_reg.sy2.measurement_function_select)
			|| (core_reg.sy2.measurement_function_select != ITC_F_TOTAL
			&& core_reg.win_q != core_reg.out.win_sel);
		if (restart)
			core_next.st = ITC_IDLE;

		if (core_reg.sy2.clear)
		begin
			// Held reset: zero, idle, lamp off
			core_next.st = ITC_IDLE;
			core_next.acc = ITC_ZERO27;
			core_next.acc_ovf = 1'b0;
			core_next.out.value = ITC_ZERO27;
			core_next.out.display_limit_exceeded = 1'b0;
			core_next.out.blank_int_digits =
				(core_reg.sy2.measurement_function_select == ITC_F_CHECK);
		end
		else if (core_reg.sy2.hold)
		begin
			// Freeze: stop measuring, keep display and total
			if (core_reg.sy2.measurement_function_select != ITC_F_TOTAL
				|| core_reg.st != ITC_IDLE)
				core_next.st = ITC_IDLE;
		end
		else if (!restart)
		begin
			case (core_reg.st)
				ITC_IDLE:
				begin
					core_next.tmr = ITC_ZERO32;
					core_next.ncyc = ITC_ZERO10;
					core_next.ref_cnt = ITC_ZERO5;
					if (core_reg.sy2.measurement_function_select == ITC_F_TOTAL)
						core_next.st = ITC_RUN;
					else if (core_reg.sy2.measurement_function_select == ITC_F_TIME)
					begin
						core_next.acc = ITC_ZERO27;
						core_next.acc_ovf = 1'b0;
						core_next.st = ITC_WAIT_A;
					end
					else if (core_reg.sy2.measurement_function_select == ITC_F_CHECK)
					begin
						core_next.acc = ITC_ZERO27;
						core_next.acc_ovf = 1'b0;
						core_next.st = ITC_RUN;
					end
				end
				ITC_WAIT_A:
				begin
					core_next.tmr = ITC_ZERO32;
					if (a_evt)
						core_next.st = ITC_RUN;
				end
				ITC_RUN:
				begin
					core_next.tmr = core_reg.tmr + 32'h1;
					if (core_reg.sy2.measurement_function_select == ITC_F_TOTAL)
					begin
						if (a_evt && gate_hi)
						begin
							if (core_reg.acc == ITC_DISP_MAX)
							begin
								core_next.acc = ITC_ZERO27;
								core_next.out.display_limit_exceeded =
									1'b1;
							end
							else
								core_next.acc = inc;
							core_next.out.value = (core_reg.acc
								== ITC_DISP_MAX) ? ITC_ZERO27
								: inc;
						end
					end
					else if (core_reg.sy2.measurement_function_select == ITC_F_CHECK)
					begin
						if (ref_tick)
						begin
							core_next.acc = (core_reg.acc == ITC_DISP_MAX)
								? ITC_ZERO27 : inc;
							if (core_reg.acc == ITC_DISP_MAX)
								core_next.acc_ovf = 1'b1;
						end
						if (core_reg.tmr == WIN_CYC[core_reg.out.win_sel]
							- 32'h1)
						begin
							core_next.out.value = core_next.acc;
							core_next.out.display_limit_exceeded =
								core_next.acc_ovf;
							core_next.out.blank_int_digits = 1'b0;
							core_next.st = ITC_IDLE;
						end
					end
					else if (b_edge)
					begin
						core_next.acc = sum[26:0];
						if (sum > {6'h0, ITC_DISP_MAX})
							core_next.acc_ovf = 1'b1;
						core_next.ncyc = core_reg.ncyc + 10'h1;
						core_next.st = ITC_WAIT_A;
						if (core_reg.ncyc + 10'h1
							== ITC_AVG_N[core_reg.out.win_sel])
						begin
							core_next.out.value = sum[26:0];
							core_next.out.display_limit_exceeded =
								core_reg.acc_ovf
								|| (sum > {6'h0, ITC_DISP_MAX});
							core_next.st = single ? ITC_DONE
								: ITC_IDLE;
						end
					end
				end
				ITC_DONE:
					core_next.st = ITC_DONE;
				default:
					core_next.st = ITC_IDLE;
			endcase
		end

		core_next.out.window_active =
			(core_next.st == ITC_WAIT_A || core_next.st == ITC_RUN)
			&& !core_reg.sy2.hold && !core_reg.sy2.clear;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			core_reg <= '0;
		else
			core_reg <= core_next;
	end

	assign disp = core_reg.out;

endmodule

// File: rtl/itc_pkg.sv
package itc_pkg;

	// Measurement function codes on the selector input
	localparam logic [1:0] ITC_F_TIME  = 2'h0;
	localparam logic [1:0] ITC_F_TOTAL = 2'h1;
	localparam logic [1:0] ITC_F_CHECK = 2'h2;

	// Window settings: 0.01 s, 0.1 s, 1.0 s, 10 s
	localparam logic [1:0] ITC_WIN_FIRST  = 2'h0;
	localparam logic [1:0] ITC_WIN_LAST   = 2'h3;
	localparam logic [1:0] ITC_WIN_MS_TOP = 2'h2;
	localparam longint ITC_WIN0_MS = 64'hA;
	localparam longint ITC_WIN1_MS = 64'h64;
	localparam longint ITC_WIN2_MS = 64'h3E8;
	localparam longint ITC_WIN3_MS = 64'h2710;

	// Core clock and internal reference, in kHz
	localparam longint ITC_CLK_KHZ = 64'h3D090;
	localparam longint ITC_REF_KHZ = 64'h2710;
	localparam logic [4:0] ITC_REF_DIV = 5'(ITC_CLK_KHZ / ITC_REF_KHZ);

	// Window lengths in core cycles
	localparam logic [3:0][31:0] ITC_WIN_CYC = {
		32'(ITC_WIN3_MS * ITC_CLK_KHZ),
		32'(ITC_WIN2_MS * ITC_CLK_KHZ),
		32'(ITC_WIN1_MS * ITC_CLK_KHZ),
		32'(ITC_WIN0_MS * ITC_CLK_KHZ)};

	// Cycles averaged per window setting
	localparam logic [3:0][9:0] ITC_AVG_N =
		{10'h3E8, 10'h64, 10'hA, 10'h1};

	localparam logic [26:0] ITC_DISP_MAX  = 27'h5F5E0FF;
	localparam logic [26:0] ITC_ZERO27    = 27'h0;
	localparam logic [31:0] ITC_ZERO32    = 32'h0;
	localparam logic [9:0]  ITC_ZERO10    = 10'h0;
	localparam logic [4:0]  ITC_ZERO5     = 5'h0;

	typedef struct packed {
		logic [1:0] measurement_function_select;
		logic       unit_ms;
		logic       hold;
		logic       clear;
		logic       win_step;
		logic       gate;
		logic       gate_present;
	} itc_panel_s;

	typedef struct packed {
		logic [26:0] value;
		logic        display_limit_exceeded;
		logic        window_active;
		logic        blank_int_digits;
		logic        lit_ms_mhz;
		logic        lit_us_khz;
		logic [1:0]  win_sel;
	} itc_disp_s;

	typedef enum logic [1:0] {
		ITC_IDLE,
		ITC_WAIT_A,
		ITC_RUN,
		ITC_DONE
	} itc_state_e;

endpackage
